// ==== ssr_consts.svh ====
`ifndef SSR_CONSTS_SVH
`define SSR_CONSTS_SVH

// ---------------------------------------------------------------
// clock and timing
// ---------------------------------------------------------------
`define SSR_MCLK_MHZ 100
`define SSR_MODE_SWITCH_FILTER_NS 2000
`define SSR_MODE_SWITCH_FILTER_CYC ((`SSR_MODE_SWITCH_FILTER_NS * `SSR_MCLK_MHZ + 999) / 1000)

// ---------------------------------------------------------------
// serial status word layout
// ---------------------------------------------------------------
`define SSR_WORD_W 32
`define SSR_BIT_LOCAL_WAKE 0
`define SSR_BIT_REMOTE_WAKE 1
`define SSR_BIT_UNUSED_HIGH 2
`define SSR_BIT_LATCH_LO 3
`define SSR_BIT_LATCH_HI 10
`define SSR_BIT_GUARDIAN 11
`define SSR_BIT_ANALOG_VER_LO 16
`define SSR_BIT_DIGITAL_VER_LO 24
`define SSR_LATCH_N 8
`define SSR_SKIP_EDGES 2

// version fields: arbitrary neutral values
`define SSR_ANALOG_VER_DEFAULT 8'h5a
`define SSR_DIGITAL_VER_DEFAULT 8'h3c

`endif

// ==== ssr_pkg.sv ====
package ssr_pkg;
  // operating modes of the surrounding mode machine
  typedef enum logic [2:0] {
    SSR_NORMAL,
    SSR_RX_ONLY,
    SSR_STANDBY,
    SSR_GO_SLEEP,
    SSR_SLEEP
  } ssr_mode_t;
endpackage

// ==== ssr_link.sv ====
`timescale 1ns/10ps
`default_nettype none
module ssr_link #(
  parameter int CNT_W = 10
) (
  input wire logic mode_ctrl_clk,
  input wire logic reset_n,
  input wire logic guardian_tx_permit,
  output logic [CNT_W-1:0] fall_cnt_gray,
  output logic guardian_smp
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic bge_s1_q;

  // ---------------------------------------------------------------
  // falling edge counter, published gray coded
  // ---------------------------------------------------------------
  assign cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};

  // count each falling edge of the mode-control clock
  always_ff @(negedge mode_ctrl_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
      fall_cnt_gray <= '0;
    end else begin
      cnt_q <= cnt_d;
      fall_cnt_gray <= cnt_d ^ (cnt_d >> 1);
    end
  end

  // guardian enable taken on rising edges, two stages
  always_ff @(posedge mode_ctrl_clk or negedge reset_n) begin
    if (!reset_n) begin
      bge_s1_q <= 1'b0;
      guardian_smp <= 1'b0;
    end else begin
      bge_s1_q <= guardian_tx_permit;
      guardian_smp <= bge_s1_q;
    end
  end
endmodule // ssr_link
`default_nettype wire

// ==== ssr_status_readout.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ssr_consts.svh"
//
// Contract
// - S0, S1 mirror wake flags, never cleared
// - S2 always reads High
// - S3..S10 latch set on flag High
// - clear only if read and flag gone
// - S11 guardian input in Normal, else Low
// - guardian input sampled on rising edge
// - S12..S15 always Low
// - S16..S31 fixed version bytes
// - indicator Low while error flag set in Normal
// - indicator works in every mode
// - bits shown inverted on falling edges
// - shifting starts at second falling edge
// - read-out starts at S0, partial allowed
// - stable input past filter ends read-out
module ssr_status_readout #(
  parameter logic [7:0] ANALOG_VER = `SSR_ANALOG_VER_DEFAULT,
  parameter logic [7:0] DIGITAL_VER = `SSR_DIGITAL_VER_DEFAULT,
  parameter int FILTER_CYC = `SSR_MODE_SWITCH_FILTER_CYC,
  parameter int CNT_W = 10
) (
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic MODE_CTRL_CLK,
  input wire logic GUARDIAN_TX_PERMIT,
  input wire ssr_pkg::ssr_mode_t OP_MODE,
  input wire logic LOCAL_WAKE_FLAG,
  input wire logic REMOTE_WAKE_FLAG,
  input wire logic ERROR_FLAG,
  input wire logic [7:0] FAULT_FLAGS,
  output logic FAULT_WAKE_INDICATOR_OUT,
  output logic READOUT_ACTIVE,
  output logic READOUT_DONE,
  output logic MODE_LEVEL
);
  import ssr_pkg::*;

  logic [CNT_W-1:0] gray_link;
  logic guardian_link;
  logic [CNT_W-1:0] gray_s1_q, gray_s2_q;
  logic [CNT_W-1:0] cnt_bin, base_q, idx;
  logic bge_s1_q, bge_s2_q;
  logic en_s1_q, en_s2_q, en_s3_q;
  logic [15:0] stable_q;
  logic active_q, done_q, level_q, fault_wake_indicator_out_q;
  logic [`SSR_LATCH_N-1:0] lat_q;
  logic [`SSR_WORD_W-1:0] word;
  logic indicator;
  logic finish;
  logic [CNT_W-1:0] bit_pos;

  // ---------------------------------------------------------------
  // link side: edge counter and guardian sampling
  // ---------------------------------------------------------------
  ssr_link #(.CNT_W(CNT_W)) u_link (
    .mode_ctrl_clk(MODE_CTRL_CLK),
    .reset_n(RESET_N),
    .guardian_tx_permit(GUARDIAN_TX_PERMIT),
    .fall_cnt_gray(gray_link),
    .guardian_smp(guardian_link)
  );

  // ---------------------------------------------------------------
  // crossings into the MCLK domain
  // ---------------------------------------------------------------
  // two stages for the gray pointer and guardian level, three for the raw input
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      gray_s1_q <= '0;
      gray_s2_q <= '0;
      bge_s1_q <= 1'b0;
      bge_s2_q <= 1'b0;
      en_s1_q <= 1'b0;
      en_s2_q <= 1'b0;
      en_s3_q <= 1'b0;
    end else begin
      gray_s1_q <= gray_link;
      gray_s2_q <= gray_s1_q;
      bge_s1_q <= guardian_link;
      bge_s2_q <= bge_s1_q;
      en_s1_q <= MODE_CTRL_CLK;
      en_s2_q <= en_s1_q;
      en_s3_q <= en_s2_q;
    end
  end

  // gray to binary
  always_comb begin
    cnt_bin = '0;
    for (int i = CNT_W - 1; i >= 0; i--) begin
      if (i == CNT_W - 1) begin
        cnt_bin[i] = gray_s2_q[i];
      end else begin
        cnt_bin[i] = cnt_bin[i+1] ^ gray_s2_q[i];
      end
    end
  end

  // falling edges since this read-out began; each one starts at S0
  assign idx = cnt_bin - base_q;
  assign bit_pos = idx - CNT_W'(`SSR_SKIP_EDGES);

  // ---------------------------------------------------------------
  // read-out framing by the mode-change filter
  // ---------------------------------------------------------------
  assign finish = active_q && (stable_q >= 16'(FILTER_CYC));

  // stability counter on the synchronised input
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      stable_q <= '0;
    end else if (en_s2_q != en_s3_q) begin
      stable_q <= '0;
    end else if (stable_q != 16'hffff) begin
      stable_q <= stable_q + 16'h0001;
    end
  end

  // activity opens a read-out, a quiet input ends it
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      active_q <= 1'b0;
      done_q <= 1'b0;
      base_q <= '0;
      level_q <= 1'b0;
    end else begin
      done_q <= finish;
      if (en_s2_q != en_s3_q) begin
        active_q <= 1'b1;
      end else if (finish) begin
        active_q <= 1'b0;
      end
      // base follows the count while idle, but not in the opening cycle:
      // the opening fall must count as edge one
      // the pointer never arrives before the pin, so base is pre-edge
      if (finish || (!active_q && en_s2_q == en_s3_q)) begin
        base_q <= cnt_bin; // next read-out restarts at S0
      end
      if (finish) begin
        level_q <= en_s2_q; // mode follows the settled level
      end
    end
  end

  // ---------------------------------------------------------------
  // latched statuses S3..S10
  // ---------------------------------------------------------------
  for (genvar j = 0; j < `SSR_LATCH_N; j++) begin : g_lat
    always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
        lat_q[j] <= 1'b0;
      end else if (FAULT_FLAGS[j]) begin
        lat_q[j] <= 1'b1; // set wins over clear
      end else if (finish && idx >= CNT_W'(j + `SSR_BIT_LATCH_LO + `SSR_SKIP_EDGES)) begin
        lat_q[j] <= 1'b0; // bit reached the pin and flag gone
      end
    end
  end

  // ---------------------------------------------------------------
  // status word and indicator
  // ---------------------------------------------------------------
  always_comb begin
    word = '0;
    word[`SSR_BIT_LOCAL_WAKE] = LOCAL_WAKE_FLAG;
    word[`SSR_BIT_REMOTE_WAKE] = REMOTE_WAKE_FLAG;
    word[`SSR_BIT_UNUSED_HIGH] = 1'b1;
    word[`SSR_BIT_LATCH_HI:`SSR_BIT_LATCH_LO] = lat_q;
    word[`SSR_BIT_GUARDIAN] = (OP_MODE == SSR_NORMAL) && bge_s2_q;
    word[`SSR_BIT_ANALOG_VER_LO +: 8] = ANALOG_VER;
    word[`SSR_BIT_DIGITAL_VER_LO +: 8] = DIGITAL_VER;
  end // S12..S15 stay zero

  // error flag in Normal, wake flags otherwise, in any mode
  assign indicator = (OP_MODE == SSR_NORMAL) ? !ERROR_FLAG :
                     !(LOCAL_WAKE_FLAG || REMOTE_WAKE_FLAG);

  // output register: shifted bit, inverted, or live indication
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      fault_wake_indicator_out_q <= 1'b1;
    end else if (!active_q || idx < CNT_W'(`SSR_SKIP_EDGES)) begin
      fault_wake_indicator_out_q <= indicator; // first edge shifts nothing
    end else if (bit_pos >= CNT_W'(`SSR_WORD_W)) begin
      fault_wake_indicator_out_q <= 1'b1; // past S31
    end else begin
      fault_wake_indicator_out_q <= !word[bit_pos[4:0]]; // inverted bit
    end
  end

  assign FAULT_WAKE_INDICATOR_OUT = fault_wake_indicator_out_q;
  assign READOUT_ACTIVE = active_q;
  assign READOUT_DONE = done_q;
  assign MODE_LEVEL = level_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  a_wake_bit_live: assert property (
    (active_q && idx == 10'd2) |=> (fault_wake_indicator_out_q == !$past(LOCAL_WAKE_FLAG)))
    else $error("S0 does not mirror local wake flag");
  a_unused_high: assert property (
    (active_q && idx == 10'd4) |=> !fault_wake_indicator_out_q)
    else $error("S2 not shown as High bit");
  a_latch_sticky: assert property (
    (FAULT_FLAGS != 8'h00) |=> ((lat_q & $past(FAULT_FLAGS)) == $past(FAULT_FLAGS)))
    else $error("fault flag not latched");
  a_unread_kept: assert property (
    (finish && idx < 10'h007 && lat_q[2]) |=> lat_q[2])
    else $error("unread status bit cleared");
  a_guard_other_mode: assert property (
    (active_q && idx == 10'd13 && OP_MODE != SSR_NORMAL) |=> fault_wake_indicator_out_q)
    else $error("S11 not Low outside Normal");
  a_unused_low: assert property (
    (active_q && idx >= 10'd14 && idx <= 10'd17) |=> fault_wake_indicator_out_q)
    else $error("S12..S15 not Low");
  a_error_shown: assert property (
    (!active_q && OP_MODE == SSR_NORMAL && ERROR_FLAG) |=> !fault_wake_indicator_out_q)
    else $error("error flag not shown Low");
  a_first_edge_quiet: assert property (
    (active_q && idx < 10'd2) |=> (fault_wake_indicator_out_q == $past(indicator)))
    else $error("bit shifted before second falling edge");
  a_filter_end: assert property (
    (active_q && stable_q == 16'(FILTER_CYC) && en_s2_q == en_s3_q) |=> done_q ##1 !active_q)
    else $error("read-out not ended after filter time");
  a_beyond_high: assert property (
    (active_q && idx >= 10'd34) |=> fault_wake_indicator_out_q)
    else $error("position beyond S31 not High");

  c_done: cover property (done_q);
  c_full_word: cover property (active_q && idx == 10'd34);
  c_partial: cover property (finish && idx > 10'd2 && idx < 10'd10);
endmodule // ssr_status_readout
`default_nettype wire

// ==== ssr_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module ssr_host_model (
  input wire logic lclk,
  input wire logic indicator,
  output logic mode_ctrl,
  output logic [39:0] cap
);
  // ---------------------------------------------------------------
  // host reading the status word
  // ---------------------------------------------------------------
  // pin idles high and stands still between read-outs
  initial begin
    mode_ctrl = 1'b1;
    cap = '0;
  end
  // n bits need n+1 falls; each bit is taken one period after its fall
  task automatic read_bits(input int n);
    cap = '0;
    for (int k = 1; k <= n + 2; k++) begin
      @(posedge lclk);
      if (k >= 3) cap[k-3] = ~indicator;
      if (k <= n + 1) begin
        mode_ctrl <= 1'b0; // first fall gives no bit
        @(negedge lclk);
        mode_ctrl <= 1'b1; // half period well inside the filter
      end
    end
  endtask
endmodule // ssr_host_model
`default_nettype wire

// ==== tb_status_shift_readout.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ssr_consts.svh"
module tb_status_shift_readout;
  import ssr_pkg::*;
  localparam int FILT = 20;
  logic mclk = 0, lclk = 0, rst_n = 0, permit = 0, lw = 0, rw = 0, err = 0;
  ssr_mode_t mode = SSR_NORMAL;
  logic [7:0] faults = 8'h00;
  wire logic ind, act, done, lvl, mctl;
  wire logic [39:0] cap;
  int n_fail = 0, check_count = 0;
  // ---------------------------------------------------------------
  // clocks and instances
  // ---------------------------------------------------------------
  always #5 mclk = ~mclk;
  always #32 lclk = ~lclk;
  ssr_status_readout #(.FILTER_CYC(FILT)) i_ssr_status_readout (
    .MCLK(mclk), .RESET_N(rst_n), .MODE_CTRL_CLK(mctl), .GUARDIAN_TX_PERMIT(permit),
    .OP_MODE(mode), .LOCAL_WAKE_FLAG(lw), .REMOTE_WAKE_FLAG(rw), .ERROR_FLAG(err),
    .FAULT_FLAGS(faults), .FAULT_WAKE_INDICATOR_OUT(ind), .READOUT_ACTIVE(act),
    .READOUT_DONE(done), .MODE_LEVEL(lvl)
  );
  ssr_host_model i_ssr_host_model (.lclk(lclk), .indicator(ind), .mode_ctrl(mctl), .cap(cap));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [39:0] got, input logic [39:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // expected word from flags, latches and guardian level
  function automatic logic [31:0] word(logic l, logic r, logic [7:0] lat, logic g);
    return {`SSR_DIGITAL_VER_DEFAULT, `SSR_ANALOG_VER_DEFAULT, 4'h0, g, lat, 1'b1, r, l};
  endfunction
  // read n bits, then wait for the end pulse under a bound
  task automatic readout(input int n);
    i_ssr_host_model.read_bits(n);
    for (int i = 0; i < 100 && done !== 1'b1; i++) @(negedge mclk);
    check({38'h0, done, act}, 40'h2, "end pulse");
    repeat (3) @(negedge mclk);
  endtask
  task automatic wrap_up;
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #100us;
    n_fail++;
    wrap_up();
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    check({37'h0, act, done, ind}, 40'h1, "reset outputs");
    @(posedge mclk) rst_n <= 1'b1;
    @(posedge mclk) err <= 1'b1;
    repeat (6) @(negedge mclk);
    check({39'h0, ind}, 40'h0, "error shown low");
    @(posedge mclk) err <= 1'b0;
    repeat (6) @(negedge mclk);
    check({39'h0, ind}, 40'h1, "error clear high");
    @(posedge mclk) begin
      mode <= SSR_STANDBY;
      lw <= 1'b1;
    end
    repeat (6) @(negedge mclk);
    check({39'h0, ind}, 40'h0, "wake shown in standby");
    $display("test idle indication done");
    @(posedge mclk) begin
      mode <= SSR_NORMAL;
      faults <= 8'hff;
      permit <= 1'b1;
    end
    @(posedge mclk) faults <= 8'h00;
    readout(34);
    check(cap, {8'h00, word(1, 0, 8'hff, 1)}, "full word");
    check({32'h0, cap[39:32]}, 40'h0, "beyond S31 high");
    check({39'h0, lvl}, 40'h1, "mode level");
    readout(32);
    check(cap, {8'h0, word(1, 0, 8'h00, 1)}, "latches cleared");
    $display("test full read-out done");
    @(posedge mclk) faults <= 8'hff;
    @(posedge mclk) begin
      faults <= 8'h02;
      mode <= SSR_STANDBY;
    end
    readout(5);
    check(cap, 40'h1d, "partial read");
    readout(32);
    check(cap, {8'h0, word(1, 0, 8'hfe, 0)}, "unread kept");
    $display("test partial read-out done");
    wrap_up();
  end
endmodule // tb_status_shift_readout
`default_nettype wire
